// ===== shared/hss_pkg.sv
// Constants and types for the hardware standby sequencer
package hss_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int MS_PER_S = 1000;
   localparam int OSC_STABLE_MS = 8;
   // Least time, so round up
   localparam int OSC_STABLE_CYCLES = (OSC_STABLE_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
   localparam int RESET_EXC_CYCLES = 16;
   localparam int PORT_WIDTH = 8;
   localparam int BOOT_WIDTH = 3;
   localparam int SYNC_DS_BIT = 0;
   localparam int SYNC_CI_BIT = 1;
   localparam int SYNC_BOOT_LSB = 2;
   localparam int SYNC_WIDTH = SYNC_BOOT_LSB + BOOT_WIDTH;
   localparam logic [SYNC_WIDTH-1:0] SYNC_RESET_VAL = 5'h00;
   localparam logic [BOOT_WIDTH-1:0] BOOT_RESET_VAL = 3'h0;

   typedef enum logic [2:0] {
      HSS_ST_STANDBY = 3'b000,
      HSS_ST_INIT    = 3'b001,
      HSS_ST_EXC     = 3'b010,
      HSS_ST_RUN     = 3'b011
   } hss_state_t;
endpackage

// ===== shared/hss_sync_if.sv
// Carrier between the sequencer and its pin synchroniser
`timescale 1ns/1ps
interface hss_sync_if #(parameter int WIDTH = 5);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// ===== rtl/hss_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module hss_sync #(
   parameter int WIDTH = 5,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic arst_n_in,
   hss_sync_if.sync port_if
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] clean_r;
   logic [WIDTH-1:0] agree;

   if (WIDTH < 1) begin : g_width_chk
      $error("hss_sync: WIDTH must be at least 1");
   end

   assign agree = ~(s2_r ^ s3_r);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s1_r <= RESET_VAL;
         s2_r <= RESET_VAL;
         s3_r <= RESET_VAL;
      end else if (!rst_n_in) begin
         s1_r <= RESET_VAL;
         s2_r <= RESET_VAL;
         s3_r <= RESET_VAL;
      end else begin
         s1_r <= port_if.raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A change counts once stages two and three agree
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         clean_r <= RESET_VAL;
      end else if (!rst_n_in) begin
         clean_r <= RESET_VAL;
      end else begin
         clean_r <= (s3_r & agree) | (clean_r & ~agree);
      end
   end

   assign port_if.clean = clean_r;
endmodule

// ===== rtl/hss_sequencer.sv
// Hardware standby entry and exit sequencer
`timescale 1ns/1ps
module hss_sequencer #(
   parameter int OSC_STABLE_CYCLES = hss_pkg::OSC_STABLE_CYCLES,
   parameter int RESET_EXC_CYCLES = hss_pkg::RESET_EXC_CYCLES,
   parameter int PORT_WIDTH = hss_pkg::PORT_WIDTH
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic deep_sleep_n_in,
   input wire logic chip_init_n_in,
   input wire logic [hss_pkg::BOOT_WIDTH-1:0] boot_config_pins_in,
   input wire logic onchip_ram_enable_in,
   input wire logic ram_we_in,
   input wire logic [PORT_WIDTH-1:0] port_wdata_in,
   input wire logic [PORT_WIDTH-1:0] port_drive_in,
   output logic [2:0] state_out,
   output logic standby_out,
   output logic func_reset_n_out,
   output logic reset_exc_out,
   output logic cpu_run_out,
   output logic osc_enable_out,
   output logic osc_stable_out,
   output logic early_release_out,
   output logic [hss_pkg::BOOT_WIDTH-1:0] boot_mode_out,
   output logic ram_en_out,
   output logic ram_we_out,
   output logic [PORT_WIDTH-1:0] port_data_out,
   output logic [PORT_WIDTH-1:0] port_oe_n_out
);
   localparam int OSC_W = (OSC_STABLE_CYCLES > 1) ? $clog2(OSC_STABLE_CYCLES + 1) : 1;
   localparam int EXC_W = (RESET_EXC_CYCLES > 1) ? $clog2(RESET_EXC_CYCLES) : 1;
   localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_STABLE_CYCLES);
   localparam logic [EXC_W-1:0] EXC_LAST = EXC_W'(RESET_EXC_CYCLES - 1);
   localparam logic [PORT_WIDTH-1:0] PORT_ALL_HIZ = '1;

   if (OSC_STABLE_CYCLES < 1) begin : g_osc_chk
      $error("hss_sequencer: OSC_STABLE_CYCLES must be at least 1");
   end
   if (RESET_EXC_CYCLES < 1) begin : g_exc_chk
      $error("hss_sequencer: RESET_EXC_CYCLES must be at least 1");
   end
   if (PORT_WIDTH < 1) begin : g_port_chk
      $error("hss_sequencer: PORT_WIDTH must be at least 1");
   end

   hss_pkg::hss_state_t state_r;
   hss_pkg::hss_state_t state_nxt;
   logic [OSC_W-1:0] osc_cnt_r;
   logic [EXC_W-1:0] exc_cnt_r;
   logic ds_clean;
   logic ci_clean;
   logic [hss_pkg::BOOT_WIDTH-1:0] boot_clean;
   logic osc_stable_r;
   logic early_release_r;
   logic [hss_pkg::BOOT_WIDTH-1:0] boot_mode_r;
   logic func_reset_n_r;
   logic reset_exc_r;
   logic cpu_run_r;
   logic osc_enable_r;
   logic standby_r;
   logic ram_en_r;
   logic ram_we_r;
   logic [PORT_WIDTH-1:0] port_data_r;
   logic [PORT_WIDTH-1:0] port_oe_n_r;
   logic [2:0] state_out_r;
   logic run_nxt;

   // Pins cross in through one shared synchroniser
   hss_sync_if #(.WIDTH(hss_pkg::SYNC_WIDTH)) sync_if ();

   assign sync_if.raw = {boot_config_pins_in, chip_init_n_in, deep_sleep_n_in};

   // Cleared with the standby pin, so no stale high survives the exit
   hss_sync #(
      .WIDTH(hss_pkg::SYNC_WIDTH),
      .RESET_VAL(hss_pkg::SYNC_RESET_VAL)
   ) u_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .arst_n_in(deep_sleep_n_in),
      .port_if(sync_if)
   );

   assign ds_clean = sync_if.clean[hss_pkg::SYNC_DS_BIT];
   assign ci_clean = sync_if.clean[hss_pkg::SYNC_CI_BIT];
   assign boot_clean = sync_if.clean[hss_pkg::SYNC_BOOT_LSB +: hss_pkg::BOOT_WIDTH];

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         hss_pkg::HSS_ST_STANDBY: begin
            // Only the pins lead out of standby
            if (ds_clean) begin
               state_nxt = hss_pkg::HSS_ST_INIT;
            end
         end
         hss_pkg::HSS_ST_INIT: begin
            if (ci_clean) begin
               state_nxt = hss_pkg::HSS_ST_EXC;
            end
         end
         hss_pkg::HSS_ST_EXC: begin
            if (!ci_clean) begin
               state_nxt = hss_pkg::HSS_ST_INIT;
            end else if (exc_cnt_r == EXC_LAST) begin
               state_nxt = hss_pkg::HSS_ST_RUN;
            end
         end
         hss_pkg::HSS_ST_RUN: begin
            if (!ci_clean) begin
               state_nxt = hss_pkg::HSS_ST_INIT;
            end
         end
         default: begin
            state_nxt = hss_pkg::HSS_ST_STANDBY;
         end
      endcase
   end

   assign run_nxt = (state_nxt == hss_pkg::HSS_ST_RUN);

   // Standby pin acts without the clock, from any state
   always_ff @(posedge clk_in or negedge deep_sleep_n_in) begin
      if (!deep_sleep_n_in) begin
         state_r <= hss_pkg::HSS_ST_STANDBY;
      end else if (!rst_n_in) begin
         state_r <= hss_pkg::HSS_ST_STANDBY;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Reset exception handling length
   always_ff @(posedge clk_in or negedge deep_sleep_n_in) begin
      if (!deep_sleep_n_in) begin
         exc_cnt_r <= '0;
      end else if (!rst_n_in || state_r != hss_pkg::HSS_ST_EXC) begin
         exc_cnt_r <= '0;
      end else if (exc_cnt_r != EXC_LAST) begin
         exc_cnt_r <= exc_cnt_r + EXC_W'(1);
      end
   end

   // Oscillator settle count, restarted by every standby
   always_ff @(posedge clk_in or negedge deep_sleep_n_in) begin
      if (!deep_sleep_n_in) begin
         osc_cnt_r <= '0;
         osc_stable_r <= 1'b0;
      end else if (!rst_n_in) begin
         osc_cnt_r <= '0;
         osc_stable_r <= 1'b0;
      end else if (state_r != hss_pkg::HSS_ST_STANDBY) begin
         if (osc_cnt_r != OSC_LAST) begin
            osc_cnt_r <= osc_cnt_r + OSC_W'(1);
         end
         osc_stable_r <= (osc_cnt_r == OSC_LAST);
      end
   end

   // Flags a chip_init_n release before the oscillator settled
   always_ff @(posedge clk_in or negedge deep_sleep_n_in) begin
      if (!deep_sleep_n_in) begin
         early_release_r <= 1'b0;
      end else if (!rst_n_in) begin
         early_release_r <= 1'b0;
      end else if (state_r == hss_pkg::HSS_ST_INIT && ci_clean && !osc_stable_r) begin
         early_release_r <= 1'b1;
      end
   end

   // Straps caught at the chip_init_n release; steady during standby
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         boot_mode_r <= hss_pkg::BOOT_RESET_VAL;
      end else if (state_r == hss_pkg::HSS_ST_INIT && state_nxt == hss_pkg::HSS_ST_EXC) begin
         boot_mode_r <= boot_clean;
      end
   end

   // Functions held in reset until reset exception handling begins
   always_ff @(posedge clk_in or negedge deep_sleep_n_in) begin
      if (!deep_sleep_n_in) begin
         func_reset_n_r <= 1'b0;
         reset_exc_r <= 1'b0;
         cpu_run_r <= 1'b0;
      end else if (!rst_n_in) begin
         func_reset_n_r <= 1'b0;
         reset_exc_r <= 1'b0;
         cpu_run_r <= 1'b0;
      end else begin
         func_reset_n_r <= (state_nxt == hss_pkg::HSS_ST_EXC) || run_nxt;
         reset_exc_r <= (state_nxt == hss_pkg::HSS_ST_EXC);
         cpu_run_r <= run_nxt;
      end
   end

   // Oscillator and standby indication
   always_ff @(posedge clk_in or negedge deep_sleep_n_in) begin
      if (!deep_sleep_n_in) begin
         osc_enable_r <= 1'b0;
         standby_r <= 1'b1;
         state_out_r <= hss_pkg::HSS_ST_STANDBY;
      end else if (!rst_n_in) begin
         osc_enable_r <= 1'b0;
         standby_r <= 1'b1;
         state_out_r <= hss_pkg::HSS_ST_STANDBY;
      end else begin
         osc_enable_r <= (state_nxt != hss_pkg::HSS_ST_STANDBY);
         standby_r <= (state_nxt == hss_pkg::HSS_ST_STANDBY);
         state_out_r <= state_nxt;
      end
   end

   // RAM strobes die at once, so no write tears stored data
   always_ff @(posedge clk_in or negedge deep_sleep_n_in) begin
      if (!deep_sleep_n_in) begin
         ram_en_r <= 1'b0;
         ram_we_r <= 1'b0;
      end else if (!rst_n_in) begin
         ram_en_r <= 1'b0;
         ram_we_r <= 1'b0;
      end else begin
         ram_en_r <= run_nxt && onchip_ram_enable_in;
         ram_we_r <= run_nxt && onchip_ram_enable_in && ram_we_in;
      end
   end

   // Ports float whenever the program is not running
   always_ff @(posedge clk_in or negedge deep_sleep_n_in) begin
      if (!deep_sleep_n_in) begin
         port_oe_n_r <= PORT_ALL_HIZ;
         port_data_r <= '0;
      end else if (!rst_n_in) begin
         port_oe_n_r <= PORT_ALL_HIZ;
         port_data_r <= '0;
      end else if (!run_nxt) begin
         port_oe_n_r <= PORT_ALL_HIZ;
         port_data_r <= '0;
      end else begin
         port_oe_n_r <= ~port_drive_in;
         port_data_r <= port_wdata_in;
      end
   end

   assign state_out = state_out_r;
   assign standby_out = standby_r;
   assign func_reset_n_out = func_reset_n_r;
   assign reset_exc_out = reset_exc_r;
   assign cpu_run_out = cpu_run_r;
   assign osc_enable_out = osc_enable_r;
   assign osc_stable_out = osc_stable_r;
   assign early_release_out = early_release_r;
   assign boot_mode_out = boot_mode_r;
   assign ram_en_out = ram_en_r;
   assign ram_we_out = ram_we_r;
   assign port_data_out = port_data_r;
   assign port_oe_n_out = port_oe_n_r;
endmodule

// ===== tb/hss_sequencer_asserts.sv
// Pin-level checks for the standby sequencer
`timescale 1ns/1ps
module hss_sequencer_asserts #(
   parameter int RESET_EXC_CYCLES = hss_pkg::RESET_EXC_CYCLES,
   parameter int PORT_WIDTH = hss_pkg::PORT_WIDTH
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic deep_sleep_n_in,
   input wire logic [PORT_WIDTH-1:0] port_drive_in,
   input wire logic [2:0] state_out,
   input wire logic standby_out,
   input wire logic func_reset_n_out,
   input wire logic reset_exc_out,
   input wire logic cpu_run_out,
   input wire logic osc_enable_out,
   input wire logic ram_en_out,
   input wire logic ram_we_out,
   input wire logic [PORT_WIDTH-1:0] port_data_out,
   input wire logic [PORT_WIDTH-1:0] port_oe_n_out
);
   localparam int EXC_LO = RESET_EXC_CYCLES - 1;
   localparam int EXC_HI = RESET_EXC_CYCLES + 1;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   property p_enter;
      !deep_sleep_n_in |-> standby_out && !func_reset_n_out;
   endproperty
   a_enter: assert property (p_enter) else $error("standby not entered");
   property p_halt;
      standby_out |-> !cpu_run_out && !reset_exc_out && !osc_enable_out;
   endproperty
   a_halt: assert property (p_halt) else $error("activity in standby");
   property p_ram;
      standby_out |-> !ram_en_out && !ram_we_out;
   endproperty
   a_ram: assert property (p_ram) else $error("ram touched in standby");
   property p_hiz;
      standby_out |-> port_oe_n_out == '1 && port_data_out == '0;
   endproperty
   a_hiz: assert property (p_hiz) else $error("ports driven in standby");
   property p_exit;
      $fell(standby_out) |-> osc_enable_out && !func_reset_n_out && state_out == 3'h1;
   endproperty
   a_exit: assert property (p_exit) else $error("bad standby exit");
   property p_wake;
      $rose(deep_sleep_n_in) |-> ##[1:6] !standby_out;
   endproperty
   a_wake: assert property (p_wake) else $error("wake too slow");
   property p_stay;
      standby_out && !deep_sleep_n_in |=> standby_out;
   endproperty
   a_stay: assert property (p_stay) else $error("standby left early");
   property p_exc;
      $rose(reset_exc_out) |-> func_reset_n_out ##[EXC_LO:EXC_HI] cpu_run_out;
   endproperty
   a_exc: assert property (p_exc) else $error("exception did not end in run");
   property p_drive;
      cpu_run_out && $past(cpu_run_out) |-> port_oe_n_out == ~$past(port_drive_in);
   endproperty
   a_drive: assert property (p_drive) else $error("port enables wrong");
endmodule
bind hss_sequencer hss_sequencer_asserts #(
   .RESET_EXC_CYCLES(RESET_EXC_CYCLES),
   .PORT_WIDTH(PORT_WIDTH)
) chk_i (
   .clk_in(clk_in),
   .rst_n_in(rst_n_in),
   .deep_sleep_n_in(deep_sleep_n_in),
   .port_drive_in(port_drive_in),
   .state_out(state_out),
   .standby_out(standby_out),
   .func_reset_n_out(func_reset_n_out),
   .reset_exc_out(reset_exc_out),
   .cpu_run_out(cpu_run_out),
   .osc_enable_out(osc_enable_out),
   .ram_en_out(ram_en_out),
   .ram_we_out(ram_we_out),
   .port_data_out(port_data_out),
   .port_oe_n_out(port_oe_n_out)
);

// ===== tb/hss_supervisor_model.sv
// Board supervisor driving the standby, init and strap pins
`timescale 1ns/1ps
module hss_supervisor_model (
   input wire logic clk_in,
   output logic deep_sleep_n_out,
   output logic chip_init_n_out,
   output logic [hss_pkg::BOOT_WIDTH-1:0] boot_out
);
   initial begin
      deep_sleep_n_out = 1'b0;
      chip_init_n_out = 1'b0;
      boot_out = 3'h5;
   end
   task automatic enter();
      @(negedge clk_in) chip_init_n_out <= 1'b0;
      repeat (2) @(negedge clk_in);
      deep_sleep_n_out <= 1'b0;
   endtask
   task automatic hold_init();
      @(negedge clk_in) chip_init_n_out <= 1'b0;
   endtask
   task automatic wake();
      @(negedge clk_in) deep_sleep_n_out <= 1'b1;
   endtask
   // Straps change only once standby is left
   task automatic strap(input logic [hss_pkg::BOOT_WIDTH-1:0] boot);
      @(negedge clk_in) boot_out <= boot;
   endtask
   task automatic release_init(input int settle);
      repeat (settle) @(negedge clk_in);
      chip_init_n_out <= 1'b1;
   endtask
endmodule

// ===== tb/hss_sequencer_bench.sv
// Self-checking bench for the standby sequencer
`timescale 1ns/1ps
module hss_sequencer_bench;
   localparam int OSC = 20;
   logic clk_in = 1'b0;
   logic rst_n_in, ds_n, ci_n, ram_en, ram_we, sb, frn, exc, run, osc, ost, early, ren, rwe;
   logic [2:0] boot, bm, st;
   logic [7:0] pwd, pdrv, pd, poe;
   int error_cnt = 0;
   int tests_run = 0;
   always #5 clk_in = ~clk_in;
   hss_supervisor_model sup (.clk_in(clk_in), .deep_sleep_n_out(ds_n), .chip_init_n_out(ci_n), .boot_out(boot));
   hss_sequencer #(.OSC_STABLE_CYCLES(OSC), .RESET_EXC_CYCLES(4)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .deep_sleep_n_in(ds_n), .chip_init_n_in(ci_n), .boot_config_pins_in(boot), .onchip_ram_enable_in(ram_en),
      .ram_we_in(ram_we), .port_wdata_in(pwd), .port_drive_in(pdrv), .state_out(st), .standby_out(sb),
      .func_reset_n_out(frn), .reset_exc_out(exc), .cpu_run_out(run), .osc_enable_out(osc), .osc_stable_out(ost),
      .early_release_out(early), .boot_mode_out(bm), .ram_en_out(ren), .ram_we_out(rwe), .port_data_out(pd),
      .port_oe_n_out(poe));
   task automatic complete_run();
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   localparam int SEL_SB = 0;
   localparam int SEL_EXC = 1;
   localparam int SEL_RUN = 2;
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %b seen %b", n, e, g);
      end
   endtask
   // Flag that a wait polls, picked by number
   function automatic logic flag(input int sel);
      if (sel == SEL_SB) begin
         return sb;
      end else if (sel == SEL_EXC) begin
         return exc;
      end
      return run;
   endfunction
   task automatic await(input int sel, input logic v);
      for (int i = 0; i < 500 && flag(sel) !== v; i++) begin
         @(negedge clk_in);
      end
      chk_bit("wait", v, flag(sel));
      if (flag(sel) !== v) begin
         complete_run();
      end
   endtask
   task automatic t_wake(input int settle, input logic [2:0] b, input logic e);
      sup.wake();
      await(SEL_SB, 1'b0);
      chk_bit("osc", 1'b1, osc);
      chk_bit("init", 1'b0, frn);
      chk("state", {5'h00, hss_pkg::HSS_ST_INIT}, {5'h00, st});
      sup.strap(b);
      sup.release_init(settle);
      await(SEL_EXC, 1'b1);
      chk_bit("func", 1'b1, frn);
      chk_bit("run", 1'b0, run);
      chk("state", {5'h00, hss_pkg::HSS_ST_EXC}, {5'h00, st});
      await(SEL_RUN, 1'b1);
      chk_bit("func", 1'b1, frn);
      chk_bit("exc", 1'b0, exc);
      chk("state", {5'h00, hss_pkg::HSS_ST_RUN}, {5'h00, st});
      chk("boot", {5'h00, b}, {5'h00, bm});
      chk_bit("early", e, early);
      chk_bit("stable", ~e, ost);
   endtask
   task automatic t_run_io();
      ram_en = 1'b1;
      ram_we = 1'b1;
      pdrv = 8'ha5;
      pwd = 8'h3c;
      repeat (2) @(negedge clk_in);
      chk("pdata", 8'h3c, pd);
      chk("poe", 8'h5a, poe);
      chk_bit("ramen", 1'b1, ren);
      chk_bit("ramwe", 1'b1, rwe);
      ram_en = 1'b0;
      repeat (2) @(negedge clk_in);
      chk_bit("ramen", 1'b0, ren);
      chk_bit("ramwe", 1'b0, rwe);
   endtask
   // Init pin dropped while running, no standby
   task automatic t_reinit();
      sup.hold_init();
      await(SEL_RUN, 1'b0);
      chk("state", {5'h00, hss_pkg::HSS_ST_INIT}, {5'h00, st});
      chk_bit("func", 1'b0, frn);
      chk_bit("standby", 1'b0, sb);
      chk("poe", 8'hff, poe);
      sup.release_init(OSC + 5);
      await(SEL_RUN, 1'b1);
      chk_bit("early", 1'b0, early);
   endtask
   task automatic t_sleep();
      ram_en = 1'b0;
      sup.enter();
      #1;
      chk_bit("standby", 1'b1, sb);
      chk("state", {5'h00, hss_pkg::HSS_ST_STANDBY}, {5'h00, st});
      chk_bit("func", 1'b0, frn);
      chk_bit("run", 1'b0, run);
      chk("poe", 8'hff, poe);
      chk("pdata", 8'h00, pd);
      chk_bit("ramen", 1'b0, ren);
      chk_bit("early", 1'b0, early);
      chk_bit("stable", 1'b0, ost);
   endtask
   task automatic t_stay();
      @(negedge clk_in);
      ram_en = 1'b1;
      sup.release_init(0);
      repeat (20) @(negedge clk_in);
      chk_bit("standby", 1'b1, sb);
      chk_bit("ramwe", 1'b0, rwe);
      sup.enter();
   endtask
   initial begin
      rst_n_in = 1'b0;
      ram_en = 1'b0;
      ram_we = 1'b0;
      pwd = 8'h00;
      pdrv = 8'h00;
      repeat (8) @(negedge clk_in);
      chk_bit("standby", 1'b1, sb);
      chk("boot", {5'h00, hss_pkg::BOOT_RESET_VAL}, {5'h00, bm});
      rst_n_in = 1'b1;
      t_wake(OSC + 5, 3'h5, 1'b0);
      t_run_io();
      t_reinit();
      t_sleep();
      t_stay();
      t_wake(2, 3'h2, 1'b1);
      t_sleep();
      complete_run();
   end
endmodule
